/* design/smp_port.sv */
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
module smp_port (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    input wire logic mosi_in,
    output logic mosi_out,
    output logic mosi_oe_n,
    input wire logic miso_in,
    output logic miso_out,
    output logic miso_oe_n,
    input wire logic ss_n
);
    logic [7:0] ctrl;
    logic [1:0] rate;
    logic [7:0] tx_buf;
    logic [7:0] tx_sh;
    logic [7:0] tx_last;
    logic [7:0] rx_sh;
    logic [7:0] rx_data;
    logic [7:0] rx_next;
    logic tx_empty, rx_full, ovr, rx_arm, ovr_arm, drop;
    logic [3:0] edge_cnt;
    logic [6:0] div_cnt;
    logic sck_prev;
    logic ss_prev;
    smp_pkg::smp_state_t state;
    logic en, mstr, clock_phase_bit, clock_polarity_bit, m_run, tick;
    logic wr_data, rd_data, rd_stat;
    logic sl_sel;
    logic sl_edge;
    logic ss_fall;
    logic start_ev;
    logic edge_ev;
    logic sample;
    logic shift;
    logic last;
    logic load_now;
    logic done;
    logic ovr_hit;
    logic din;

    assign en = ctrl[smp_pkg::CB_EN];
    assign mstr = ctrl[smp_pkg::CB_MSTR];
    assign clock_phase_bit = ctrl[smp_pkg::CB_CLOCK_PHASE_BIT];
    assign clock_polarity_bit = ctrl[smp_pkg::CB_CLOCK_POLARITY_BIT];
    assign m_run = en && mstr;
    assign wr_data = wr && addr == smp_pkg::OFS_DATA;
    assign rd_data = rd && addr == smp_pkg::OFS_DATA;
    assign rd_stat = rd && addr == smp_pkg::OFS_STAT;

    // Free-running divider, stopped to save power
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            div_cnt <= 7'h00;
        else if (!m_run || tick)
            div_cnt <= 7'h00;
        else
            div_cnt <= div_cnt + 7'h01;
    end
    assign tick = m_run && div_cnt == smp_pkg::half_of(rate);

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sck_prev <= 1'b0;
            ss_prev <= 1'b1;
        end
        else
        begin
            sck_prev <= sck_in;
            ss_prev <= ss_n;
        end
    end

    // Slave ignores the clock while deselected
    assign sl_sel = en && !mstr && !ss_n;
    assign sl_edge = sl_sel && sck_in != sck_prev;
    assign ss_fall = en && !mstr && ss_prev && !ss_n;

    always_comb
    begin
        start_ev = 1'b0;
        edge_ev = 1'b0;
        if (mstr)
        begin
            start_ev = state == smp_pkg::ST_ARMED && tick;
            edge_ev = tick && (state == smp_pkg::ST_SHIFT || (start_ev && clock_phase_bit));
        end
        else
        begin
            start_ev = state == smp_pkg::ST_IDLE && (clock_phase_bit ? sl_edge : ss_fall);
            edge_ev = sl_edge && (state == smp_pkg::ST_SHIFT || (start_ev && clock_phase_bit));
        end
    end

    // Even edges lead; phase picks sample or shift edge
    assign sample = edge_ev && edge_cnt[0] == clock_phase_bit;
    assign shift = edge_ev && edge_cnt[0] != clock_phase_bit && edge_cnt != 4'h0;
    assign last = edge_ev && edge_cnt == smp_pkg::LAST_EDGE;
    assign load_now = en && !tx_empty && state == smp_pkg::ST_IDLE;
    assign ovr_hit = sample && edge_cnt[3:1] == smp_pkg::BIT1_SAMPLE && rx_full;
    assign done = last && !drop && !ovr_hit;
    assign din = mstr ? miso_in : mosi_in;
    assign rx_next = sample ? {rx_sh[6:0], din} : rx_sh;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            state <= smp_pkg::ST_IDLE;
        else if (!en)
            state <= smp_pkg::ST_IDLE;
        else
        begin
            unique case (state)
                smp_pkg::ST_IDLE:
                begin
                    if (mstr && load_now)
                        state <= smp_pkg::ST_ARMED;
                    else if (!mstr && start_ev)
                        state <= smp_pkg::ST_SHIFT;
                end
                smp_pkg::ST_ARMED:
                begin
                    if (!mstr)
                        state <= smp_pkg::ST_IDLE;
                    else if (start_ev)
                        state <= smp_pkg::ST_SHIFT;
                end
                smp_pkg::ST_SHIFT:
                begin
                    // Deselect aborts a slave byte mid-way
                    if (last || (!mstr && ss_n))
                        state <= smp_pkg::ST_IDLE;
                end
                default:
                    state <= smp_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            edge_cnt <= 4'h0;
        else if (edge_ev)
            edge_cnt <= edge_cnt + 4'h1;
        else if (state != smp_pkg::ST_SHIFT)
            edge_cnt <= 4'h0;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tx_buf <= 8'h00;
        else if (wr_data)
            tx_buf <= wdata;
    end

    // A write wins over the load of the older byte
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tx_empty <= 1'b1;
        else if (wr_data)
            tx_empty <= 1'b0;
        else if (load_now)
            tx_empty <= 1'b1;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tx_last <= 8'h00;
        else if (load_now)
            tx_last <= tx_buf;
    end

    // Buffer reaches the shifter only when idle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            tx_sh <= 8'h00;
        else if (load_now)
            tx_sh <= tx_buf;
        else if (!mstr && start_ev)
            tx_sh <= tx_last;
        else if (shift)
            tx_sh <= {tx_sh[6:0], 1'b0};
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rx_sh <= 8'h00;
        else
            rx_sh <= rx_next;
    end

    // Set on an overrun holds until the next start or the return to idle
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            drop <= 1'b0;
        else if (ovr_hit || (sample && ovr))
            drop <= 1'b1;
        else if (start_ev || state == smp_pkg::ST_IDLE)
            drop <= 1'b0;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rx_data <= 8'h00;
        else if (done)
            rx_data <= rx_next;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rx_full <= 1'b0;
        else if (done)
            rx_full <= 1'b1;
        else if (rd_data && rx_arm)
            rx_full <= 1'b0;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ovr <= 1'b0;
        else if (ovr_hit)
            ovr <= 1'b1;
        else if (rd_data && ovr_arm)
            ovr <= 1'b0;
    end

    // First step of the two-step clears
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rx_arm <= 1'b0;
            ovr_arm <= 1'b0;
        end
        else if (rd_stat)
        begin
            rx_arm <= rx_full;
            ovr_arm <= ovr;
        end
        else if (rd_data)
        begin
            rx_arm <= 1'b0;
            ovr_arm <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            ctrl <= smp_pkg::CTRL_RST;
        else if (wr && addr == smp_pkg::OFS_CTRL)
            ctrl <= wdata & smp_pkg::CTRL_MASK;
        else if (wr_data)
            ctrl[smp_pkg::CB_TXIE] <= 1'b0;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rate <= smp_pkg::RATE_RST;
        else if (wr && addr == smp_pkg::OFS_STAT)
            rate <= wdata[1:0];
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (!rd)
            rdata <= 8'h00;
        else
        begin
            unique case (addr)
                smp_pkg::OFS_CTRL: rdata <= ctrl;
                smp_pkg::OFS_STAT: rdata <= {rx_full, ovr, 2'h0, tx_empty, 1'b0, rate};
                smp_pkg::OFS_DATA: rdata <= rx_data;
                default: rdata <= 8'h00;
            endcase
        end
    end

    // Master clock rests at the polarity level
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            sck_out <= 1'b0;
        else if (mstr && edge_ev)
            sck_out <= !sck_out;
        else if (state != smp_pkg::ST_SHIFT)
            sck_out <= clock_polarity_bit;
    end

    assign mosi_out = tx_sh[7];
    assign miso_out = tx_sh[7];
    assign sck_oe_n = !m_run;
    assign mosi_oe_n = !m_run;
    assign miso_oe_n = !sl_sel;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_rx_full_set: assert property (mstr && done |=> rx_full && rx_data == $past(rx_next))
        else $error("master end did not store byte");
    a_rx_clear_seq: assert property ($fell(rx_full) |-> $past(rd_data && rx_arm))
        else $error("full cleared without status then data read");
    a_slave_store: assert property (!mstr && done |=> rx_full ##0 rx_data == $past(rx_next))
        else $error("slave byte not stored");
    a_tx_load: assert property (mstr && en && wr_data && state == smp_pkg::ST_IDLE ##1 !wr_data
        |=> tx_empty && state == smp_pkg::ST_ARMED)
        else $error("master write not moved to shifter");
    a_tx_hold: assert property (state == smp_pkg::ST_SHIFT && wr_data |=> !tx_empty)
        else $error("byte left buffer during transfer");
    a_start_delay: assert property ($rose(state == smp_pkg::ST_ARMED) && m_run
        |-> ##[1:128] state == smp_pkg::ST_SHIFT || !m_run)
        else $error("master start later than one bit time");
    a_fast_rate: assert property (m_run && rate == 2'h0 && edge_ev && edge_cnt != smp_pkg::LAST_EDGE
        && state == smp_pkg::ST_SHIFT ##1 m_run && rate == 2'h0 |-> edge_ev)
        else $error("divide-by-two rate edge missing");
    a_div8_rate: assert property (m_run && rate == 2'h1 && tick ##1 (m_run && rate == 2'h1) [*4]
        |-> tick && !$past(tick) && !$past(tick, 2) && !$past(tick, 3))
        else $error("divide-by-eight spacing wrong");
    a_clock_off: assert property (!m_run |-> !tick && sck_oe_n)
        else $error("master clock runs while not master");
    a_phase0_idle: assert property (mstr && !clock_phase_bit && start_ev |=> sck_out == $past(clock_polarity_bit))
        else $error("phase0 first half not inactive");
    a_idle_level: assert property (m_run && state == smp_pkg::ST_IDLE && $past(state == smp_pkg::ST_IDLE)
        && $stable(clock_polarity_bit) |-> sck_out == clock_polarity_bit)
        else $error("idle clock not at polarity level");
    a_miso_hiz: assert property (ss_n || mstr || !en |-> miso_oe_n)
        else $error("miso driven while deselected");
    a_ovr_keep: assert property (ovr_hit |=> ovr ##0 $stable(rx_data) [*2])
        else $error("overrun lost or old byte overwritten");
    a_slave_start0: assert property (ss_fall && !clock_phase_bit && state == smp_pkg::ST_IDLE
        |=> state == smp_pkg::ST_SHIFT)
        else $error("phase0 select fall did not start");
    a_resend: assert property (!mstr && start_ev && !load_now |=> tx_sh == $past(tx_last))
        else $error("late slave write did not resend");
    a_slave_edge: assert property (!mstr && state == smp_pkg::ST_SHIFT && sl_edge
        && edge_cnt != smp_pkg::LAST_EDGE |=> edge_cnt == $past(edge_cnt) + 4'h1)
        else $error("slave missed a clock edge");
    a_msb_first: assert property (mstr && load_now |=> mosi_out == $past(tx_buf[7]))
        else $error("first bit out is not msb");

    c_master_byte: cover property (mstr && done);
    c_slave_byte: cover property (!mstr && done);
    c_overrun: cover property (ovr_hit);
    c_slave_abort: cover property (!mstr && state == smp_pkg::ST_SHIFT && ss_n);
endmodule : smp_port

/* design/smp_pkg.sv */
package smp_pkg;
    // Register offsets
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_STAT = 8'h11;
    localparam logic [7:0] OFS_DATA = 8'h12;
    // Control field positions
    localparam int CB_TXIE = 0;
    localparam int CB_EN = 1;
    localparam int CB_CLOCK_PHASE_BIT = 2;
    localparam int CB_CLOCK_POLARITY_BIT = 3;
    localparam int CB_MSTR = 5;
    localparam logic [7:0] CTRL_MASK = 8'h2f;
    localparam logic [7:0] CTRL_RST = 8'h24;
    // Status field positions
    localparam int SB_RXF = 7;
    localparam int SB_OVR = 6;
    localparam int SB_TXE = 3;
    localparam logic [1:0] RATE_RST = 2'h0;
    // Bus clock dividers for the four rates
    localparam int DIV_R0 = 2;
    localparam int DIV_R1 = 8;
    localparam int DIV_R2 = 32;
    localparam int DIV_R3 = 128;
    // Edge counts within one byte
    localparam logic [3:0] LAST_EDGE = 4'hf;
    localparam logic [2:0] BIT1_SAMPLE = 3'h6;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_ARMED = 3'b010,
        ST_SHIFT = 3'b100
    } smp_state_t;

    // Divider compare value: half a serial period less one
    function automatic logic [6:0] half_of(input logic [1:0] rs);
        logic [6:0] h;
        h = 7'h00;
        unique case (rs)
            2'h0: h = 7'(DIV_R0 / 2 - 1);
            2'h1: h = 7'(DIV_R1 / 2 - 1);
            2'h2: h = 7'(DIV_R2 / 2 - 1);
            2'h3: h = 7'(DIV_R3 / 2 - 1);
        endcase
        return h;
    endfunction : half_of
endpackage : smp_pkg

/* verif/smp_peer.sv */
`timescale 1ns/1ns
// Behavioural slave on the far side of a master transfer
module smp_peer (
    input wire logic sck,
    input wire logic mosi,
    input wire logic sel_n,
    input wire logic clock_polarity_bit,
    input wire logic clock_phase_bit,
    input wire logic [7:0] tx,
    output logic miso,
    output logic [7:0] rx
);
    logic [7:0] sh;
    initial
    begin
        miso = 1'b0;
        rx = 8'h00;
        sh = 8'h00;
    end
    always @(negedge sel_n)
    begin
        sh = tx;
        miso = tx[7];
    end
    // Released line shows the inverse, never a stale bit
    always @(posedge sel_n)
        miso = ~miso;
    always @(sck)
    begin
        // Let the launching edge settle before looking at mosi
        #1;
        if (!sel_n)
        begin
            if ((sck != clock_polarity_bit) ^ clock_phase_bit)
            begin
                rx = {rx[6:0], mosi};
                if (clock_phase_bit)
                    sh = sh << 1;
            end
            else
            begin
                if (!clock_phase_bit)
                    sh = sh << 1;
                miso = sh[7];
            end
        end
    end
endmodule : smp_peer

/* verif/tb_spi_master_slave_port.sv */
`timescale 1ns/1ns
module tb_spi_master_slave_port;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sck_in = 1'b0;
    logic mosi_in = 1'b0;
    logic ss_n = 1'b1;
    logic psel_n = 1'b1;
    logic pcpol = 1'b0;
    logic pcpha = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] ptx = 8'h00;
    logic [7:0] prx;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [7:0] m;
    logic [7:0] t;
    logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, miso_peer;
    int errors = 0;
    int samples_checked = 0;
    int seed = 89879;
    int cyc = 0;
    int edges = 0;
    int t0;

    smp_port smp_port_i (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sck_in(sck_in), .sck_out(sck_out), .sck_oe_n(sck_oe_n), .mosi_in(mosi_in),
        .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n), .miso_in(miso_peer), .miso_out(miso_out),
        .miso_oe_n(miso_oe_n), .ss_n(ss_n));
    smp_peer smp_peer_i (.sck(sck_out), .mosi(mosi_out), .sel_n(psel_n), .clock_polarity_bit(pcpol), .clock_phase_bit(pcpha),
        .tx(ptx), .miso(miso_peer), .rx(prx));

    always #25 mclk = ~mclk;
    always @(posedge mclk) cyc <= cyc + 1;
    always @(sck_out) edges++;

    task results();
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results

    task check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wreg

    task rreg(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rreg

    task mxfer(input logic [1:0] rs, input logic [1:0] md);
        int div;
        logic [7:0] tx;
        div = 2 << (2 * rs);
        tx = 8'($random(seed));
        ptx = 8'($random(seed));
        pcpha = md[0];
        pcpol = md[1];
        wreg(smp_pkg::OFS_CTRL, {4'h2, md, 2'h0});
        #1;
        check(8'(sck_oe_n), 8'h01);
        wreg(smp_pkg::OFS_CTRL, {4'h2, md, 2'h2});
        wreg(smp_pkg::OFS_STAT, {6'h00, rs});
        #1;
        check(8'({sck_oe_n, mosi_oe_n, miso_oe_n}), 8'h01);
        psel_n <= 1'b0;
        edges = 0;
        wreg(smp_pkg::OFS_DATA, tx);
        t0 = cyc;
        v = 8'h00;
        for (int k = 0; k < 700 && v[7] !== 1'b1; k++)
            rreg(smp_pkg::OFS_STAT, v);
        check(8'(cyc - t0 <= 9 * div + 8), 8'h01);
        // Every mode spans fifteen half periods from first to last edge
        check(8'(cyc - t0 >= 15 * div / 2), 8'h01);
        check(8'(edges), 8'h10);
        rreg(smp_pkg::OFS_DATA, m);
        check(m, ptx);
        check(prx, tx);
        rreg(smp_pkg::OFS_STAT, m);
        check(m, {6'h02, rs});
        psel_n <= 1'b1;
    endtask : mxfer

    // Testbench acts as master; bus-rate runs use h of 1
    task sxfer(input logic [7:0] tx, input int h, input logic clock_phase_bit, output logic [7:0] got);
        @(posedge mclk);
        check(8'(miso_oe_n), 8'h01);
        ss_n <= 1'b0;
        repeat (h) @(posedge mclk);
        check(8'(miso_oe_n), 8'h00);
        for (int i = 7; i >= 0; i--)
        begin
            if (clock_phase_bit)
                sck_in <= 1'b1;
            mosi_in <= tx[i];
            repeat (h) @(posedge mclk);
            got[i] = miso_out;
            sck_in <= !clock_phase_bit;
            repeat (h) @(posedge mclk);
            if (!clock_phase_bit)
                sck_in <= 1'b0;
        end
        repeat (h) @(posedge mclk);
        // Select toggles between bytes, needed for phase 0
        ss_n <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask : sxfer

    initial
    begin
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rreg(smp_pkg::OFS_CTRL, v);
        check(v, smp_pkg::CTRL_RST);
        rreg(smp_pkg::OFS_STAT, v);
        check(v, 8'h08);
        rreg(smp_pkg::OFS_DATA, v);
        check(v, 8'h00);
        wreg(8'h13, 8'hff);
        rreg(8'h13, v);
        check(v, 8'h00);
        wreg(smp_pkg::OFS_CTRL, 8'hd0);
        rreg(smp_pkg::OFS_CTRL, v);
        check(v, 8'h00);
        for (int r = 0; r < 4; r++)
            for (int md = 0; md < 4; md++)
                mxfer(2'(r), 2'(md));
        for (int c = 0; c < 2; c++)
        begin
            wreg(smp_pkg::OFS_CTRL, {5'h00, 1'(c), 2'h0});
            wreg(smp_pkg::OFS_CTRL, {5'h00, 1'(c), 2'h2});
            #1;
            check(8'(sck_oe_n), 8'h01);
            t = 8'($random(seed));
            m = 8'($random(seed));
            wreg(smp_pkg::OFS_DATA, t);
            sxfer(m, 4, 1'(c), v);
            check(v, t);
            rreg(smp_pkg::OFS_STAT, v);
            check(8'(v[7]), 8'h01);
            rreg(smp_pkg::OFS_DATA, v);
            check(v, m);
            sxfer(m, 4, 1'(c), v);
            check(v, t);
            rreg(smp_pkg::OFS_STAT, v);
            rreg(smp_pkg::OFS_DATA, v);
            m = 8'($random(seed));
            sxfer(m, 1, 1'(c), v);
            rreg(smp_pkg::OFS_STAT, v);
            rreg(smp_pkg::OFS_DATA, v);
            check(v, m);
            t = ~m;
            sxfer(m, 2, 1'(c), v);
            sxfer(t, 2, 1'(c), v);
            rreg(smp_pkg::OFS_STAT, v);
            check(v & 8'hc0, 8'hc0);
            rreg(smp_pkg::OFS_DATA, v);
            check(v, m);
            rreg(smp_pkg::OFS_STAT, v);
            check(v & 8'hc0, 8'h00);
        end
        results();
    end

    initial
    begin
        repeat (40000) @(posedge mclk);
        errors++;
        results();
    end
endmodule : tb_spi_master_slave_port
